// ---- fpu_stack_pkg.sv ----
// Purpose: shared constants, command encodings and carriers for the
//          numeric register stack and its status and control words
// Assumes: one clock, synchronous active-low reset
// Notes:   environment image layout for the save and load commands
`default_nettype none

package fpu_stack_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W  = 80;
  localparam int unsigned NUM_REG = 8;
  localparam int unsigned IDX_W   = 3;
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned EXC_W   = 6;

  // ---------------------------------------------------------------
  // status word layout
  // ---------------------------------------------------------------
  localparam int unsigned SW_EXC_LSB = 0;
  localparam int unsigned SW_FAULT   = 6;
  localparam int unsigned SW_SUMMARY = 7;
  localparam int unsigned SW_CC0     = 8;
  localparam int unsigned SW_CC1     = 9;
  localparam int unsigned SW_CC2     = 10;
  localparam int unsigned SW_CC3     = 11;
  localparam int unsigned SW_TOP_LSB = 12;
  localparam int unsigned SW_B       = 15;

  // exception flag positions, shared by status flags and control masks
  localparam int unsigned EXC_INVALID = 0;
  localparam int unsigned EXC_INEXACT = 5;

  // ---------------------------------------------------------------
  // control word layout and values after reset
  // ---------------------------------------------------------------
  localparam int unsigned CW_MASK_LSB = 0;
  localparam int unsigned CW_PREC_LSB = 8;
  localparam int unsigned CW_RC_LSB   = 10;
  localparam logic [15:0] CW_USED     = 16'h0f3f;
  localparam logic [15:0] CW_RESET    = 16'h033f;
  localparam logic [2:0]  TOP_RESET   = 3'h0;

  // ---------------------------------------------------------------
  // field encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] PREC_SINGLE = 2'h0;
  localparam logic [1:0] PREC_DOUBLE = 2'h2;
  localparam logic [1:0] PREC_EXT    = 2'h3;
  localparam logic [1:0] RND_NEAR    = 2'h0;
  localparam logic [1:0] RND_DOWN    = 2'h1;
  localparam logic [1:0] RND_UP      = 2'h2;
  localparam logic [1:0] RND_ZERO    = 2'h3;
  localparam logic [1:0] TAG_VALID   = 2'h0;
  localparam logic [1:0] TAG_ZERO    = 2'h1;
  localparam logic [1:0] TAG_SPECIAL = 2'h2;
  localparam logic [1:0] TAG_EMPTY   = 2'h3;
  localparam logic [14:0] EXP_ONES   = 15'h7fff;

  // environment image packed into the data field
  localparam int unsigned ENV_CW_LSB  = 0;
  localparam int unsigned ENV_SW_LSB  = 16;
  localparam int unsigned ENV_TAG_LSB = 32;

  // ---------------------------------------------------------------
  // commands from the host
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP       = 4'h0,
    OP_PUSH      = 4'h1,
    OP_POP_STORE = 4'h2,
    OP_STORE     = 4'h3,
    OP_RESULT    = 4'h4,
    OP_LD_CW     = 4'h5,
    OP_ST_CW     = 4'h6,
    OP_ST_SW     = 4'h7,
    OP_INIT      = 4'h8,
    OP_CLEX      = 4'h9,
    OP_LD_ENV    = 4'ha,
    OP_ST_ENV    = 4'hb,
    OP_SAVE      = 4'hc,
    OP_RESTORE   = 4'hd
  } op_t;

  typedef enum logic [2:0] {
    CC_NONE    = 3'h0,
    CC_REMAIN  = 3'h1,
    CC_COMPARE = 3'h2,
    CC_TRIG    = 3'h3,
    CC_ROUND   = 3'h4
  } cc_kind_t;

  typedef struct packed {
    logic [5:0] exc;
    cc_kind_t   kind;
    logic [3:0] cc;
    logic       incomplete;
    logic       roundup;
    logic       arith;
    logic       write;
  } result_t;

  typedef struct packed {
    op_t         op;
    logic [2:0]  rel;
    logic [79:0] data;
    result_t     res;
  } cmd_t;

endpackage : fpu_stack_pkg

`default_nettype wire

// ---- fpu_stack_regs.sv ----
// Purpose: eight physical 80-bit registers with empty/full tracking
// Assumes: indices are physical, already wrapped by the caller
// Notes:   read port is combinational
`timescale 1ns/1ps
`default_nettype none

module fpu_stack_regs
  import fpu_stack_pkg::*;
(
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  // write port
  input  wire logic         wr_en_in,
  input  wire logic [2:0]   wr_idx_in,
  input  wire logic [79:0]  wr_data_in,
  // read port
  input  wire logic [2:0]   rd_idx_in,
  output logic      [79:0]  rd_data_out,
  // occupancy control
  input  wire logic [7:0]   full_set_in,
  input  wire logic [7:0]   full_clr_in,
  input  wire logic         full_load_in,
  input  wire logic [7:0]   full_val_in,
  output logic      [7:0]   full_out,
  output logic      [15:0]  tag_word_out
);

  logic [79:0] regs_q [NUM_REG];
  logic [7:0]  full_q;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      regs_q[wr_idx_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      full_q <= 8'h00;
    end else if (full_load_in) begin
      full_q <= full_val_in;
    end else begin
      full_q <= (full_q & ~full_clr_in) | full_set_in;
    end
  end

  assign rd_data_out = regs_q[rd_idx_in];
  assign full_out    = full_q;

  // ---------------------------------------------------------------
  // detailed tags, one per physical register
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NUM_REG; g++) begin : g_tag
    always_comb begin
      if (!full_q[g]) begin
        tag_word_out[2*g +: 2] = TAG_EMPTY;
      end else if (regs_q[g][78:0] == 79'h0) begin
        tag_word_out[2*g +: 2] = TAG_ZERO;
      end else if (regs_q[g][78:64] == EXP_ONES || !regs_q[g][63]) begin
        tag_word_out[2*g +: 2] = TAG_SPECIAL;
      end else begin
        tag_word_out[2*g +: 2] = TAG_VALID;
      end
    end
  end

endmodule // fpu_stack_regs

`default_nettype wire

// ---- fpu_stack_status_control.sv ----
// Purpose: register stack, status word and control word of the
//          numeric coprocessor, driven by host commands
// Assumes: one command per cycle while cmd_valid_in is high
// Notes:   all outputs registered; answers appear one cycle later
`timescale 1ns/1ps
`default_nettype none

module fpu_stack_status_control
  import fpu_stack_pkg::*;
(
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  // host command
  input  wire logic         cmd_valid_in,
  input  wire cmd_t         cmd_in,
  // host answer
  output logic              data_valid_out,
  output logic      [79:0]  data_out,
  // architectural state
  output logic      [15:0]  status_out,
  output logic      [15:0]  control_out,
  output logic      [7:0]   full_out,
  // arithmetic options
  output logic      [1:0]   prec_out,
  output logic      [1:0]   round_out,
  // error pin
  output logic              error_n_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [2:0]  top_q, top_d;
  logic [5:0]  exc_q, exc_d;
  logic        flt_q, flt_d;
  logic [3:0]  cc_q, cc_d;
  logic [15:0] cw_q, cw_d;
  logic        sum_d;
  logic [15:0] sw_d;

  logic [79:0] data_q, data_d;
  logic        dvalid_q, dvalid_d;
  logic [15:0] sw_q;
  logic [1:0]  prec_q, prec_d;
  logic [1:0]  round_q, round_d;
  logic        error_n_q;

  // ---------------------------------------------------------------
  // register array controls
  // ---------------------------------------------------------------
  logic        wr_en;
  logic [2:0]  wr_idx;
  logic [79:0] wr_data;
  logic [2:0]  rd_idx;
  logic [79:0] rd_data;
  logic [7:0]  full_set;
  logic [7:0]  full_clr;
  logic        full_load;
  logic [7:0]  full_val;
  logic [7:0]  full;
  logic [15:0] tag_word;

  // ---------------------------------------------------------------
  // addressing
  // ---------------------------------------------------------------
  op_t         op;
  result_t     res;
  logic [2:0]  rel_idx;
  logic [2:0]  push_idx;
  logic [2:0]  pop_top;
  logic [15:0] env_cw;
  logic [15:0] env_sw;
  logic [15:0] env_tag;
  logic [7:0]  env_full;

  assign op       = cmd_valid_in ? cmd_in.op : OP_NOP;
  assign res      = cmd_in.res;
  assign rel_idx  = 3'(top_q + cmd_in.rel);
  assign push_idx = 3'(top_q - 3'h1);
  assign pop_top  = 3'(top_q + 3'h1);
  assign env_cw   = cmd_in.data[ENV_CW_LSB +: WORD_W];
  assign env_sw   = cmd_in.data[ENV_SW_LSB +: WORD_W];
  assign env_tag  = cmd_in.data[ENV_TAG_LSB +: WORD_W];

  for (genvar g = 0; g < NUM_REG; g++) begin : g_env
    assign env_full[g] = env_tag[2*g +: 2] != TAG_EMPTY;
  end

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  always_comb begin
    top_d     = top_q;
    exc_d     = exc_q;
    flt_d     = flt_q;
    cc_d      = cc_q;
    cw_d      = cw_q;
    data_d    = data_q;
    dvalid_d  = 1'b0;
    wr_en     = 1'b0;
    wr_idx    = rel_idx;
    wr_data   = cmd_in.data;
    rd_idx    = rel_idx;
    full_set  = 8'h00;
    full_clr  = 8'h00;
    full_load = 1'b0;
    full_val  = 8'h00;
    unique case (op)
      OP_PUSH: begin
        if (full[push_idx]) begin
          // overflow: target still occupied, stack left intact
          exc_d[EXC_INVALID] = 1'b1;
          flt_d              = 1'b1;
          cc_d[1]            = 1'b1;
        end else begin
          top_d              = push_idx;
          wr_en              = 1'b1;
          wr_idx             = push_idx;
          full_set[push_idx] = 1'b1;
          cc_d[1]            = 1'b0;
        end
      end
      OP_POP_STORE, OP_STORE: begin
        rd_idx   = (op == OP_POP_STORE) ? top_q : rel_idx;
        dvalid_d = 1'b1;
        if (!full[rd_idx]) begin
          // underflow: nothing to read
          exc_d[EXC_INVALID] = 1'b1;
          flt_d              = 1'b1;
          cc_d[1]            = 1'b0;
          data_d             = 80'h0;
        end else begin
          data_d = rd_data;
          if (op == OP_POP_STORE) begin
            full_clr[top_q] = 1'b1;
            top_d           = pop_top;
          end
        end
      end
      OP_RESULT: begin
        exc_d = exc_q | res.exc;
        unique case (res.kind)
          CC_REMAIN: begin
            cc_d[0] = res.cc[2];
            cc_d[1] = res.cc[1];
            cc_d[3] = res.cc[0];
            cc_d[2] = res.incomplete;
          end
          CC_COMPARE: begin
            cc_d[0] = res.cc[0];
            cc_d[3] = res.cc[3];
            cc_d[2] = res.cc[2];
            cc_d[1] = 1'b0;
          end
          CC_TRIG: begin
            cc_d[2] = res.incomplete;
            if (!res.incomplete) begin
              cc_d[1] = res.roundup;
            end
          end
          CC_ROUND: begin
            if (exc_d[EXC_INEXACT]) begin
              cc_d[1] = res.roundup;
            end else begin
              cc_d[1] = 1'b0;
            end
          end
          default: begin
          end
        endcase
        // an out-of-range trig operand stays where it was
        if (res.write && !(res.kind == CC_TRIG && res.incomplete)) begin
          wr_en             = 1'b1;
          full_set[rel_idx] = 1'b1;
        end
      end
      OP_LD_CW: begin
        cw_d = cmd_in.data[15:0] & CW_USED;
      end
      OP_ST_CW: begin
        dvalid_d = 1'b1;
        data_d   = {64'h0, cw_q};
      end
      OP_ST_SW: begin
        dvalid_d = 1'b1;
        data_d   = {64'h0, sw_q};
      end
      OP_INIT: begin
        cw_d      = CW_RESET;
        top_d     = TOP_RESET;
        exc_d     = 6'h00;
        flt_d     = 1'b0;
        cc_d      = 4'h0;
        full_load = 1'b1;
        full_val  = 8'h00;
      end
      OP_CLEX: begin
        exc_d = 6'h00;
        flt_d = 1'b0;
      end
      OP_LD_ENV, OP_RESTORE: begin
        cw_d      = env_cw & CW_USED;
        exc_d     = env_sw[SW_EXC_LSB +: EXC_W];
        flt_d     = env_sw[SW_FAULT];
        cc_d      = {env_sw[SW_CC3], env_sw[SW_CC2],
                     env_sw[SW_CC1], env_sw[SW_CC0]};
        top_d     = env_sw[SW_TOP_LSB +: IDX_W];
        full_load = 1'b1;
        full_val  = env_full;
      end
      OP_ST_ENV: begin
        dvalid_d = 1'b1;
        data_d   = {32'h0, tag_word, sw_q, cw_q};
      end
      OP_SAVE: begin
        dvalid_d  = 1'b1;
        data_d    = {32'h0, tag_word, sw_q, cw_q};
        // save leaves the unit freshly initialised
        cw_d      = CW_RESET;
        top_d     = TOP_RESET;
        exc_d     = 6'h00;
        flt_d     = 1'b0;
        cc_d      = 4'h0;
        full_load = 1'b1;
        full_val  = 8'h00;
      end
      default: begin
      end
    endcase
  end

  // ---------------------------------------------------------------
  // status word assembly
  // ---------------------------------------------------------------
  always_comb begin
    sum_d = |(exc_d & ~cw_d[CW_MASK_LSB +: EXC_W]);
    sw_d = 16'h0000;
    sw_d[SW_EXC_LSB +: EXC_W] = exc_d;
    sw_d[SW_FAULT]            = flt_d;
    sw_d[SW_SUMMARY]          = sum_d;
    sw_d[SW_CC0]              = cc_d[0];
    sw_d[SW_CC1]              = cc_d[1];
    sw_d[SW_CC2]              = cc_d[2];
    sw_d[SW_CC3]              = cc_d[3];
    sw_d[SW_TOP_LSB +: IDX_W] = top_d;
    sw_d[SW_B]                = sum_d;
  end

  // ---------------------------------------------------------------
  // arithmetic options
  // ---------------------------------------------------------------
  always_comb begin
    prec_d  = PREC_EXT;
    round_d = RND_NEAR;
    if (op == OP_RESULT && res.arith) begin
      prec_d  = cw_q[CW_PREC_LSB +: 2];
    end
    if (op == OP_RESULT && res.kind != CC_COMPARE) begin
      round_d = cw_q[CW_RC_LSB +: 2];
    end
  end

  // ---------------------------------------------------------------
  // stack head and flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      top_q <= TOP_RESET;
    end else begin
      top_q <= top_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      exc_q <= 6'h00;
      flt_q <= 1'b0;
      cc_q  <= 4'h0;
    end else begin
      exc_q <= exc_d;
      flt_q <= flt_d;
      cc_q  <= cc_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cw_q <= CW_RESET;
    end else begin
      cw_q <= cw_d;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      data_q   <= 80'h0;
      dvalid_q <= 1'b0;
    end else begin
      data_q   <= data_d;
      dvalid_q <= dvalid_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sw_q      <= 16'h0000;
      error_n_q <= 1'b1;
    end else begin
      sw_q      <= sw_d;
      error_n_q <= ~sum_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      prec_q  <= PREC_EXT;
      round_q <= RND_NEAR;
    end else begin
      prec_q  <= prec_d;
      round_q <= round_d;
    end
  end

  assign data_valid_out = dvalid_q;
  assign data_out       = data_q;
  assign status_out     = sw_q;
  assign control_out    = cw_q;
  assign full_out       = full;
  assign prec_out       = prec_q;
  assign round_out      = round_q;
  assign error_n_out    = error_n_q;

  // ---------------------------------------------------------------
  // physical registers
  // ---------------------------------------------------------------
  fpu_stack_regs u_regs (
    .clk_in       (clk_in),
    .rstn_in      (rstn_in),
    .wr_en_in     (wr_en),
    .wr_idx_in    (wr_idx),
    .wr_data_in   (wr_data),
    .rd_idx_in    (rd_idx),
    .rd_data_out  (rd_data),
    .full_set_in  (full_set),
    .full_clr_in  (full_clr),
    .full_load_in (full_load),
    .full_val_in  (full_val),
    .full_out     (full),
    .tag_word_out (tag_word)
  );

endmodule // fpu_stack_status_control

`default_nettype wire

// ---- fpu_host_model.sv ----
// Purpose: host side issuing commands to the register stack block
// Assumes: one command per call, driven just after the next rising edge and taken at the edge after that
// Notes:   idle command lines toggle so stale values never look valid
`timescale 1ns/1ps
`default_nettype none

module fpu_host_model
  import fpu_stack_pkg::*;
(
  // clock and state
  input  wire logic        clk_in,
  input  wire logic [15:0] status_in,
  // command
  output var  logic        cmd_valid_out,
  output var  cmd_t        cmd_out,
  // host flags: zero, parity, carry
  output var  logic [2:0]  host_flags_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
  end

  // cond one is dropped by the host
  assign host_flags_out = {status_in[SW_CC3], status_in[SW_CC2],
                           status_in[SW_CC0]};

  task automatic send(input op_t o, input logic [2:0] r,
                      input logic [79:0] d, input result_t s);
    @(posedge clk_in);
    #1;
    cmd_out = '{op: o, rel: r, data: d, res: s};
    cmd_valid_out = 1'b1;
    @(posedge clk_in);
    #1;
    cmd_valid_out = 1'b0;
    cmd_out = cmd_t'(~cmd_out);
  endtask
endmodule // fpu_host_model

`default_nettype wire

// ---- fpu_stack_status_control_sva.sv ----
// Purpose: port checks of the stack, status and control block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to the design top
`timescale 1ns/1ps
`default_nettype none

module fpu_stack_status_control_sva
  import fpu_stack_pkg::*;
(
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rstn_in,
  // command
  input wire logic        cmd_valid_in,
  input wire cmd_t        cmd_in,
  // answers
  input wire logic        data_valid_out,
  input wire logic [79:0] data_out,
  input wire logic [15:0] status_out,
  input wire logic [15:0] control_out,
  input wire logic [7:0]  full_out,
  input wire logic [1:0]  prec_out,
  input wire logic [1:0]  round_out,
  input wire logic        error_n_out
);
  // ----
  // helpers
  // ----
  logic [2:0] top;
  logic       go;
  assign top = status_out[14:12];
  assign go  = cmd_valid_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  // ----
  // checks
  // ----
  AST_ERR_PIN: assert property (error_n_out == !status_out[7])
    else $error("error pin disagrees with summary");
  AST_B_BIT: assert property (status_out[15] == status_out[7])
    else $error("bit 15 differs from summary");
  AST_SUMMARY: assert property
    (status_out[7] == |(status_out[5:0] & ~control_out[5:0]))
    else $error("summary not from unmasked flags");
  AST_PUSH: assert property (go &&
    cmd_in.op == OP_PUSH && !full_out[top - 3'h1] |=>
    top == $past(top) - 3'h1 && full_out[top])
    else $error("push did not move head down");
  AST_PUSH_FULL: assert property (go && cmd_in.op == OP_PUSH &&
    full_out[top - 3'h1] |=> $stable(top) && status_out[0] &&
    status_out[6] && status_out[9])
    else $error("overflow not flagged");
  AST_POP: assert property (go && cmd_in.op == OP_POP_STORE &&
    full_out[top] |=> data_valid_out && top == $past(top) + 3'h1)
    else $error("pop did not move head up");
  AST_POP_EMPTY: assert property (go &&
    cmd_in.op == OP_POP_STORE && !full_out[top] |=>
    data_out == 80'h0 && !status_out[9] && status_out[6])
    else $error("underflow not flagged");
  AST_STICKY: assert property (!(go && cmd_in.op inside {
    OP_INIT, OP_CLEX, OP_LD_ENV, OP_SAVE, OP_RESTORE}) |=>
    (status_out[5:0] & $past(status_out[5:0])) == $past(status_out[5:0]))
    else $error("sticky flag lost");
  AST_LD_CW: assert property (go && cmd_in.op == OP_LD_CW |=>
    control_out == ($past(cmd_in.data[15:0]) & CW_USED))
    else $error("control load wrong");
  AST_ST_SW: assert property (go && cmd_in.op == OP_ST_SW |=>
    data_valid_out && data_out[15:0] == $past(status_out))
    else $error("status read wrong");
  AST_IDLE: assert property (!go |=> !data_valid_out)
    else $error("answer without command");
  AST_PREC: assert property (go &&
    cmd_in.op == OP_RESULT |=> prec_out == ($past(cmd_in.res.arith) ?
    $past(control_out[9:8]) : PREC_EXT))
    else $error("precision output wrong");
  AST_ROUND: assert property (go && cmd_in.op == OP_RESULT &&
    cmd_in.res.kind != CC_COMPARE |=> round_out == $past(control_out[11:10]))
    else $error("rounding output wrong");

  COV_OVERFLOW: cover property (go && cmd_in.op == OP_PUSH && &full_out);
  COV_UNDERFLOW: cover property (go && cmd_in.op == OP_POP_STORE &&
    !full_out[top]);
  COV_ERROR: cover property (!error_n_out);
endmodule // fpu_stack_status_control_sva

bind fpu_stack_status_control fpu_stack_status_control_sva u_sva (
  .clk_in(clk_in),
  .rstn_in(rstn_in),
  .cmd_valid_in(cmd_valid_in),
  .cmd_in(cmd_in),
  .data_valid_out(data_valid_out),
  .data_out(data_out),
  .status_out(status_out),
  .control_out(control_out),
  .full_out(full_out),
  .prec_out(prec_out),
  .round_out(round_out),
  .error_n_out(error_n_out)
);

`default_nettype wire

// ---- tb_fpu_stack_status_control.sv ----
// Purpose: self-checking bench of the stack, status and control block
// Assumes: host model issues one command every second cycle
// Notes:   random data from a bench lfsr seeded with 61
`timescale 1ns/1ps
`default_nettype none

module tb_fpu_stack_status_control;
  import fpu_stack_pkg::*;
  // ----
  // signals
  // ----
  logic        clk_in;
  logic        rstn_in;
  logic        cmd_valid;
  cmd_t        cmd;
  logic        data_valid;
  logic [79:0] data;
  logic [15:0] status;
  logic [15:0] control;
  logic [7:0]  full;
  logic [1:0]  prec;
  logic [1:0]  round;
  logic        error_n;
  logic [2:0]  flags;
  logic [79:0] model [8];
  logic [79:0] v;
  logic [15:0] lfsr_q;
  logic [15:0] w;
  logic [2:0]  t;
  logic [3:0]  ce;
  cc_kind_t    k;
  int          n_errors;
  int          check_count;
  int          cycles;
  int          i;
  localparam result_t NR = '0;

  fpu_stack_status_control u_dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .cmd_valid_in(cmd_valid), .cmd_in(cmd), .data_valid_out(data_valid),
    .data_out(data), .status_out(status), .control_out(control),
    .full_out(full), .prec_out(prec), .round_out(round),
    .error_n_out(error_n));
  fpu_host_model u_host (.clk_in(clk_in), .status_in(status),
    .cmd_valid_out(cmd_valid), .cmd_out(cmd), .host_flags_out(flags));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // ----
  // helpers
  // ----
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic result_t mk(input logic [5:0] e, input cc_kind_t c,
                                 input logic [3:0] q, input logic [3:0] f);
    return result_t'({e, c, q, f});
  endfunction
  // cond codes, three down to zero
  function automatic logic [3:0] cc_exp(input cc_kind_t c,
                                        input logic [3:0] q, input logic n);
    if (c == CC_REMAIN) return {q[0], n, q[1], q[2]};
    return {q[3], q[2], 1'b0, q[0]};
  endfunction
  task automatic rnd(output logic [79:0] r);
    for (int j = 0; j < 5; j++) begin
      lfsr_q = lfsr_next(lfsr_q);
      r = {r[63:0], lfsr_q};
    end
  endtask
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic pop_check();
    u_host.send(OP_POP_STORE, 3'h0, v, NR);
    check(data, model[t]);
    check({data_valid, full[t]}, 2'b10);
    t = t + 3'h1;
    check(status[14:12], t);
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // ----
  // scenarios
  // ----
  initial begin
    rstn_in = 1'b0;
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    lfsr_q = 16'h003d;
    t = 3'h0;
    repeat (8) @(posedge clk_in);
    #1 rstn_in = 1'b1;
    check(control, CW_RESET);
    check({error_n, prec, round, data_valid, status},
          {1'b1, PREC_EXT, RND_NEAR, 1'b0, 16'h0000});
    for (i = 0; i < 8; i++) begin
      rnd(v);
      t = t - 3'h1;
      model[t] = v;
      u_host.send(OP_PUSH, 3'h0, v, NR);
      check({status[14:12], full[t]}, {t, 1'b1});
    end
    check(full, 8'hff);
    u_host.send(OP_PUSH, 3'h0, v, NR);
    check({status[14:12], status[9], status[6], status[0]}, 6'h07);
    for (i = 0; i < 3; i++) pop_check();
    rnd(v);
    model[1] = v;
    u_host.send(OP_RESULT, 3'h6, v, mk(6'h00, CC_NONE, 4'h0, 4'h1));
    check(full[1], 1'b1);
    for (i = 0; i < 7; i++) begin
      if (i == 5) continue;
      u_host.send(OP_STORE, 3'(i), v, NR);
      check(data, model[t + 3'(i)]);
    end
    check(status[0], 1'b1);
    for (i = 0; i < 8; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      k = i[0] ? CC_REMAIN : CC_COMPARE;
      u_host.send(OP_RESULT, 3'h0, v, mk(6'h0, k, lfsr_q[3:0],
                  {lfsr_q[4], 3'h0}));
      ce = cc_exp(k, lfsr_q[3:0], lfsr_q[4]);
      check(status[11:8], ce);
      check(flags, {ce[3], ce[2], ce[0]});
    end
    u_host.send(OP_RESULT, 3'h0, ~v, mk(6'h00, CC_TRIG, 4'h0, 4'h9));
    check(status[10], 1'b1);
    u_host.send(OP_STORE, 3'h0, v, NR);
    check(data, model[t]);
    u_host.send(OP_RESULT, 3'h0, v, mk(6'h20, CC_ROUND, 4'h0, 4'h4));
    check(status[9], 1'b1);
    u_host.send(OP_CLEX, 3'h0, v, NR);
    u_host.send(OP_RESULT, 3'h0, v, mk(6'h00, CC_ROUND, 4'h0, 4'h4));
    check(status[9], 1'b0);
    u_host.send(OP_LD_CW, 3'h0, 80'h0, NR);
    check(control, 16'h0000);
    u_host.send(OP_RESULT, 3'h0, v, mk(6'h04, CC_NONE, 4'h0, 4'h0));
    check({error_n, status[15], status[7]}, 3'b011);
    u_host.send(OP_LD_CW, 3'h0, 80'h4, NR);
    check({error_n, status[7]}, 2'b10);
    u_host.send(OP_ST_CW, 3'h0, v, NR);
    check(data, 80'h4);
    w = status;
    u_host.send(OP_ST_SW, 3'h0, v, NR);
    check(data[15:0], w);
    for (i = 0; i < 16; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      w = {lfsr_q[15:12], i[3:0], lfsr_q[7:0]};
      u_host.send(OP_LD_CW, 3'h0, {64'h0, w}, NR);
      check(control, w & CW_USED);
      u_host.send(OP_RESULT, 3'h0, v, mk(6'h0, CC_NONE, 4'h0, 4'h2));
      check({prec, round}, {i[1:0], i[3:2]});
    end
    u_host.send(OP_RESULT, 3'h0, v, NR);
    check(prec, PREC_EXT);
    for (i = 0; i < 2; i++) begin
      u_host.send(OP_ST_ENV, 3'h0, v, NR);
      v = data;
      lfsr_q = lfsr_next(lfsr_q);
      v[27:24] = lfsr_q[3:0];
      v[21:16] = lfsr_q[9:4];
      u_host.send(i == 1 ? OP_RESTORE : OP_LD_ENV, 3'h0, v, NR);
      check({status[5:0], status[11:8]}, lfsr_q[9:0]);
    end
    u_host.send(OP_CLEX, 3'h0, v, NR);
    for (i = 0; i < 5; i++) pop_check();
    u_host.send(OP_POP_STORE, 3'h0, v, NR);
    check(data, 80'h0);
    check({status[14:12], status[9], status[6]}, 5'h01);
    for (i = 0; i < 3; i++) begin
      u_host.send(OP_RESULT, 3'h0, v, mk(6'h3f, CC_NONE, 4'h0, 4'h0));
      u_host.send(i == 0 ? OP_INIT : i == 1 ? OP_CLEX : OP_SAVE, 3'h0, v, NR);
      check(status[5:0], 6'h00);
    end
    check({control, full}, {CW_RESET, 8'h00});
    report_and_stop();
  end
endmodule // tb_fpu_stack_status_control

`default_nettype wire
